// ### verilog/eda_params.svh
/*
  Offsets, field positions, key bytes and timing counts of the EEPROM
  access controller. Assumes inclusion by bare name from design files.
*/
`ifndef EDA_PARAMS_SVH
`define EDA_PARAMS_SVH

// Register byte offsets on the APB slave.
`define EDA_OFF_CONTROL   12'h000
`define EDA_OFF_UNLOCK    12'h004
`define EDA_OFF_ADDRESS   12'h008
`define EDA_OFF_DATA      12'h00C
`define EDA_OFF_IRQ_STAT  12'h010
`define EDA_OFF_IRQ_MASK  12'h014

// Control register field positions.
`define EDA_CTL_RD        0
`define EDA_CTL_WR        1
`define EDA_CTL_PERMIT    2
`define EDA_CTL_ABORT     3

// Interrupt status field positions.
`define EDA_IRQ_DONE      0
`define EDA_IRQ_ABORT     1

// Unlock key bytes.
`define EDA_KEY_FIRST     8'h55
`define EDA_KEY_SECOND    8'hAA

// Exact clock cycles from the first key write to the strobe set: each
// transfer takes two cycles with a setup and one access cycle; back to back.
`define EDA_UNLOCK_CYCLES 4

// Programming interval.
`define EDA_PROG_TIME_US  5
`define EDA_CLK_MHZ       25

`endif

// ### verilog/eda_pkg.sv
/*
  Types of the EEPROM access controller.
  Assumes eda_params.svh supplies the numeric constants.
*/
package eda_pkg;

  typedef enum logic [2:0] {
    EDA_IDLE  = 3'b001,
    EDA_KEY1  = 3'b010,
    EDA_KEY2  = 3'b100
  } eda_unlock_t;

  typedef struct packed {
    logic       req;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eda_mem_req_t;

endpackage : eda_pkg

// ### verilog/eda_array.sv
/*
  Byte array standing in for the EEPROM cells, with a programming timer.
  Assumes the controller holds a write request for one cycle only.
*/
`timescale 1ns/1ps
`include "eda_params.svh"

module eda_array #(
  parameter int DEPTH      = 256,
  parameter int PROG_CYCLES = 125
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // Request
  input  wire eda_pkg::eda_mem_req_t mreq,
  // Answer
  output logic [7:0]             rdata,
  output logic                   busy,
  output logic                   done
);

  logic [7:0]  mem [DEPTH];
  logic [15:0] cnt_r;

  assign rdata = mem[mreq.addr];

  // Cells only change after the programming interval.
  always_ff @(posedge pclk) begin
    if (busy && cnt_r == 16'h0001) begin
      mem[mreq.addr] <= mreq.wdata;
    end
  end

  // RULE19 timed programming interval
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 16'h0000;
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= busy && cnt_r == 16'h0001;
      if (mreq.req && mreq.we && !busy) begin
        cnt_r <= 16'(PROG_CYCLES);
        busy  <= 1'b1;
      end else if (busy) begin
        cnt_r <= cnt_r - 16'h0001;
        busy  <= cnt_r != 16'h0001;
      end
    end
  end

endmodule : eda_array

// ### verilog/eda_ctrl.sv
/*
  APB-reached access controller for a byte-wide data EEPROM: read strobe,
  unlock-protected write strobe, abort flag, done interrupt.
  Assumes an APB master on pclk and a system reset cause input set.
*/
// Contract
// RULE1 - Control register bits 7 to 4 always read zero.
// RULE2 - Read and write strobes set only by software; hardware clears at finish.
// RULE3 - Write permit clear at power-up; clear permit blocks array writes.
// RULE4 - Hardware never clears write permit by itself.
// RULE5 - Abort flag set when pin, watchdog or brown-out reset cuts a write.
// RULE6 - Reset during a write clears the address and data registers.
// RULE7 - Write finish clears write strobe and sets sticky done flag.
// RULE8 - Unlock register has no storage and reads zero.
// RULE9 - Read strobe fetches addressed byte into data register in one cycle.
// RULE10 - Data register keeps last read byte until next read or write.
// RULE11 - Firmware loads address and data before starting a write.
// RULE12 - Write starts only after 55h then AAh to unlock, then strobe.
// RULE13 - Exact cycle count across unlock sequence, otherwise write refused.
// RULE14 - Write strobe sets only while write permit already set.
// RULE15 - Clearing write permit mid-write does not disturb the write.
// RULE16 - Firmware should mask interrupts across the unlock sequence.
// RULE17 - Firmware should not touch registers while write strobe set.
// RULE18 - Firmware should keep write permit clear except when updating.
// RULE19 - Write strobe stays set for a programmed interval before completion.
`timescale 1ns/1ps
`include "eda_params.svh"

module eda_ctrl #(
  parameter int ADDR_W      = 8,
  parameter int PROG_CYCLES = (`EDA_PROG_TIME_US * `EDA_CLK_MHZ)
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Cause of the last reset, sampled after release
  input  wire logic        por_reset,
  input  wire logic        warm_reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq
);

  logic        rd_r, wr_r, permit_r, abort_r;
  logic [7:0]  addr_r, data_r;
  logic [1:0]  stat_r, mask_r;
  logic [7:0]  cyc_r;
  logic        busy_seen_r, init_r;
  eda_pkg::eda_unlock_t ul_r, ul_nxt;
  eda_pkg::eda_mem_req_t mreq;
  logic [7:0]  arr_rdata;
  logic        arr_busy, arr_done;

  // APB decode: one-cycle access phase, always ready.
  wire acc      = psel && penable;
  wire wr_acc   = acc && pwrite;
  wire sel_ctl  = paddr == `EDA_OFF_CONTROL;
  wire sel_unl  = paddr == `EDA_OFF_UNLOCK;
  wire sel_adr  = paddr == `EDA_OFF_ADDRESS;
  wire sel_dat  = paddr == `EDA_OFF_DATA;
  wire sel_st   = paddr == `EDA_OFF_IRQ_STAT;
  wire sel_msk  = paddr == `EDA_OFF_IRQ_MASK;
  wire mapped   = sel_ctl | sel_unl | sel_adr | sel_dat | sel_st | sel_msk;
  wire w_ctl    = wr_acc && sel_ctl;
  wire w_unl    = wr_acc && sel_unl;
  wire set_rd   = w_ctl && pwdata[`EDA_CTL_RD];
  wire try_wr   = w_ctl && pwdata[`EDA_CTL_WR];

  // RULE12 key order tracker
  always_comb begin
    ul_nxt = ul_r;
    if (w_unl) begin
      if (ul_r == eda_pkg::EDA_IDLE && pwdata[7:0] == `EDA_KEY_FIRST) begin
        ul_nxt = eda_pkg::EDA_KEY1;
      end else if (ul_r == eda_pkg::EDA_KEY1 && pwdata[7:0] == `EDA_KEY_SECOND) begin
        ul_nxt = eda_pkg::EDA_KEY2;
      end else begin
        ul_nxt = eda_pkg::EDA_IDLE;
      end
    end else if (wr_acc || (acc && !pwrite && sel_unl)) begin
      ul_nxt = eda_pkg::EDA_IDLE;
    end
  end

  // RULE13 exact cycle count since first key
  wire count_ok = cyc_r == 8'(`EDA_UNLOCK_CYCLES);
  // RULE14 permit already set when strobe attempted
  wire start_wr = try_wr && permit_r && !wr_r && ul_r == eda_pkg::EDA_KEY2 && count_ok;

  assign mreq.req   = start_wr;
  assign mreq.we    = 1'b1;
  assign mreq.addr  = addr_r;
  assign mreq.wdata = data_r;

  eda_array #(
    .DEPTH       (1 << ADDR_W),
    .PROG_CYCLES (PROG_CYCLES)
  ) u_array (
    .pclk    (pclk),
    .presetn (presetn),
    .mreq    (mreq),
    .rdata   (arr_rdata),
    .busy    (arr_busy),
    .done    (arr_done)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ul_r  <= eda_pkg::EDA_IDLE;
      cyc_r <= 8'h00;
    end else begin
      ul_r  <= ul_nxt;
      cyc_r <= (w_unl && ul_r == eda_pkg::EDA_IDLE) ? 8'h01 :
               (cyc_r != 8'hFF && cyc_r != 8'h00) ? cyc_r + 8'h01 : cyc_r;
      if (ul_nxt == eda_pkg::EDA_IDLE) begin
        cyc_r <= 8'h00;
      end
    end
  end

  // RULE2 strobes set by software only, cleared by hardware
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else begin
      // RULE9 read strobe lasts one cycle
      rd_r <= set_rd && !wr_r;
      // RULE7 finish clears write strobe
      if (start_wr) begin
        wr_r <= 1'b1;
      end else if (arr_done) begin
        wr_r <= 1'b0;
      end
    end
  end

  // RULE3 permit cleared at power-up
  // RULE4 only software changes permit
  // RULE15 permit change leaves running write alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      permit_r <= 1'b0;
    end else if (w_ctl) begin
      permit_r <= pwdata[`EDA_CTL_PERMIT];
    end
  end

  // The controller sees a reset only as presetn; the reset cause inputs and
  // a strobe-shadow flop are read on the first clock after release.
  logic wr_shadow_r;
  // The shadow freezes while reset is low, so it still shows a cut write after release.
  always_ff @(posedge pclk) begin
    if (presetn) begin
      wr_shadow_r <= wr_r;
    end
  end

  // RULE5 abort flag from reset during a write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_r  <= 1'b1;
      abort_r <= 1'b0;
    end else begin
      init_r <= 1'b0;
      if (init_r && warm_reset && !por_reset && wr_shadow_r === 1'b1) begin
        abort_r <= 1'b1;
      end else if (w_ctl) begin
        abort_r <= pwdata[`EDA_CTL_ABORT];
      end
    end
  end

  // RULE6 address and data clear at reset
  // RULE10 data held until next read or write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_r <= 8'h00;
      data_r <= 8'h00;
    end else begin
      if (wr_acc && sel_adr && !wr_r) begin
        addr_r <= pwdata[7:0];
      end
      if (rd_r) begin
        data_r <= arr_rdata;
      end else if (wr_acc && sel_dat && !wr_r) begin
        data_r <= pwdata[7:0];
      end
    end
  end
  assign busy_seen_r = arr_busy;

  // RULE7 sticky done flag, set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_r <= 2'b00;
      mask_r <= 2'b00;
      irq    <= 1'b0;
    end else begin
      stat_r[`EDA_IRQ_DONE]  <= arr_done |
        (stat_r[`EDA_IRQ_DONE] & !(wr_acc && sel_st && pwdata[`EDA_IRQ_DONE]));
      stat_r[`EDA_IRQ_ABORT] <= (init_r && warm_reset && !por_reset && wr_shadow_r === 1'b1) |
        (stat_r[`EDA_IRQ_ABORT] & !(wr_acc && sel_st && pwdata[`EDA_IRQ_ABORT]));
      if (wr_acc && sel_msk) begin
        mask_r <= pwdata[1:0];
      end
      irq <= |(stat_r & mask_r);
    end
  end

  // RULE1 upper bits zero
  // RULE8 unlock reads zero
  wire [7:0] ctl_rd = {4'h0, abort_r, permit_r, wr_r, rd_r};
  wire [31:0] rd_mux = sel_ctl ? {24'h000000, ctl_rd} :
                       sel_adr ? {24'h000000, addr_r} :
                       sel_dat ? {24'h000000, data_r} :
                       sel_st  ? {30'h00000000, stat_r} :
                       sel_msk ? {30'h00000000, mask_r} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // Helper count of cycles that the write strobe has been high.
  logic [15:0] wr_hi_cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_hi_cnt <= 16'h0000;
    end else begin
      wr_hi_cnt <= wr_r ? wr_hi_cnt + 16'h0001 : 16'h0000;
    end
  end

  sequence s_key_pair;
    w_unl && pwdata[7:0] == `EDA_KEY_FIRST ##2 w_unl && pwdata[7:0] == `EDA_KEY_SECOND;
  endsequence

  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && sel_ctl |-> prdata[7:4] == 4'h0) // RULE1
    else $error("Control upper bits not zero.");
  a_strobe_hold: assert property (@(posedge pclk) disable iff (!presetn)
    wr_r && !arr_done |=> wr_r) // RULE2
    else $error("Write strobe dropped early.");
  a_permit_block: assert property (@(posedge pclk) disable iff (!presetn)
    !permit_r |-> !start_wr) // RULE3
    else $error("Write started without permit.");
  a_permit_keep: assert property (@(posedge pclk) disable iff (!presetn)
    !w_ctl |=> permit_r == $past(permit_r)) // RULE4
    else $error("Permit changed without software.");
  a_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
    arr_done |=> stat_r[`EDA_IRQ_DONE] && !wr_r) // RULE7
    else $error("Done flag not set at finish.");
  a_unlock_zero: assert property (@(posedge pclk) disable iff (!presetn)
    pready && !pwrite && sel_unl |-> prdata == 32'h00000000) // RULE8
    else $error("Unlock register read nonzero.");
  a_read_fetch: assert property (@(posedge pclk) disable iff (!presetn)
    set_rd && !wr_r |=> ##1 data_r == $past(arr_rdata)) // RULE9
    else $error("Read data not loaded.");
  a_unlock_order: assert property (@(posedge pclk) disable iff (!presetn)
    s_key_pair ##2 (try_wr && permit_r && !wr_r) |=> wr_r) // RULE12
    else $error("Unlocked write did not start.");
  a_strobe_permit: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(wr_r) |-> $past(permit_r)) // RULE14
    else $error("Write strobe set without permit.");
  a_prog_time: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(wr_r) |-> $past(wr_hi_cnt) >= 16'(PROG_CYCLES)) // RULE19
    else $error("Write strobe shorter than interval.");

endmodule : eda_ctrl

// ### testbench/eda_fw.sv
/*
  APB master standing for the processor core that runs the firmware.
  Assumes a slave on pclk that answers each access with pready.
*/
`timescale 1ns/1ps

module eda_fw (
  // Clock
  input  wire logic        pclk,
  // APB request
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  // APB answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end

  // The request is left up after the answer, so transfers chain with no idle cycle.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
  endtask : xfer

  task automatic idle();
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : idle
endmodule : eda_fw

// ### testbench/eda_ctrl_tb_top.sv
/*
  Self-checking bench of the EEPROM access controller.
  Assumes eda_fw as the APB master and a short programming interval.
*/
`timescale 1ns/1ps
`include "eda_params.svh"

module eda_ctrl_tb_top;
  // A short interval still leaves room to touch the control register mid-write.
  localparam int PROG = 40;
  logic        pclk, presetn, por_reset, warm_reset;
  logic        psel, penable, pwrite, pready, pslverr, irq, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, v;
  int          n_fail, num_checks, cyc;

  eda_ctrl #(.PROG_CYCLES(PROG)) dut (.pclk(pclk), .presetn(presetn), .por_reset(por_reset),
    .warm_reset(warm_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq));
  eda_fw fw (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic check(input string nm, input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    fw.xfer(1'b1, a, d, v, e);
    fw.idle();
  endtask : wr

  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] x);
    fw.xfer(1'b0, a, 32'h0, v, e);
    fw.idle();
    check(nm, v, x);
  endtask : rchk

  // key order; the gap option breaks the cycle count.
  task automatic unlock(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c,
                        input bit gap);
    fw.xfer(1'b1, `EDA_OFF_UNLOCK, {24'h0, k1}, v, e);
    if (gap) fw.idle();
    fw.xfer(1'b1, `EDA_OFF_UNLOCK, {24'h0, k2}, v, e);
    fw.xfer(1'b1, `EDA_OFF_CONTROL, {24'h0, c}, v, e);
    fw.idle();
  endtask : unlock

  // here the firmware only polls status while the write runs.
  task automatic wait_done();
    v = 32'h0;
    for (int i = 0; i < 40 && v[0] !== 1'b1; i++) begin
      fw.xfer(1'b0, `EDA_OFF_IRQ_STAT, 32'h0, v, e);
      fw.idle();
    end
  endtask : wait_done

  task automatic do_rst(input logic w);
    presetn    <= 1'b0;
    por_reset  <= ~w;
    warm_reset <= w;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask : do_rst

  initial begin
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    presetn = 1'b0;
    por_reset = 1'b1;
    warm_reset = 1'b0;
    @(posedge pclk);
    do_rst(1'b0);
    rchk("control", `EDA_OFF_CONTROL, 32'h0);
    fw.xfer(1'b0, 12'h020, 32'h0, v, e);
    fw.idle();
    check("slverr", {31'h0, e}, 32'h1);
    wr(`EDA_OFF_ADDRESS, 32'h10);
    wr(`EDA_OFF_DATA, 32'h5A);
    unlock(8'h55, 8'hAA, 8'h02, 1'b0);
    rchk("control", `EDA_OFF_CONTROL, 32'h0);
    rchk("status", `EDA_OFF_IRQ_STAT, 32'h0);
    wr(`EDA_OFF_CONTROL, 32'hF4);
    rchk("control", `EDA_OFF_CONTROL, 32'h4);
    unlock(8'hAA, 8'h55, 8'h06, 1'b0);
    rchk("control", `EDA_OFF_CONTROL, 32'h4);
    unlock(8'h55, 8'hAA, 8'h06, 1'b1);
    rchk("control", `EDA_OFF_CONTROL, 32'h4);
    rchk("unlock", `EDA_OFF_UNLOCK, 32'h0);
    unlock(8'h55, 8'hAA, 8'h06, 1'b0);
    rchk("control", `EDA_OFF_CONTROL, 32'h6);
    wr(`EDA_OFF_CONTROL, 32'h0);
    rchk("control", `EDA_OFF_CONTROL, 32'h2);
    wait_done();
    check("status", v, 32'h1);
    rchk("control", `EDA_OFF_CONTROL, 32'h0);
    check("irq", {31'h0, irq}, 32'h0);
    wr(`EDA_OFF_IRQ_MASK, 32'h1);
    @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h1);
    wr(`EDA_OFF_IRQ_STAT, 32'h1);
    @(posedge pclk);
    check("irq", {31'h0, irq}, 32'h0);
    rchk("status", `EDA_OFF_IRQ_STAT, 32'h0);
    wr(`EDA_OFF_CONTROL, 32'h1);
    rchk("control", `EDA_OFF_CONTROL, 32'h0);
    rchk("data", `EDA_OFF_DATA, 32'h5A);
    wr(`EDA_OFF_ADDRESS, 32'h11);
    rchk("data", `EDA_OFF_DATA, 32'h5A);
    wr(`EDA_OFF_DATA, 32'hC3);
    wr(`EDA_OFF_CONTROL, 32'h4);
    unlock(8'h55, 8'hAA, 8'h06, 1'b0);
    wait_done();
    check("status", v, 32'h1);
    rchk("control", `EDA_OFF_CONTROL, 32'h4);
    wr(`EDA_OFF_CONTROL, 32'h5);
    rchk("data", `EDA_OFF_DATA, 32'hC3);
    unlock(8'h55, 8'hAA, 8'h06, 1'b0);
    do_rst(1'b1);
    fw.xfer(1'b0, `EDA_OFF_CONTROL, 32'h0, v, e);
    fw.idle();
    check("abort", v & 32'h8, 32'h8);
    fw.xfer(1'b0, `EDA_OFF_IRQ_STAT, 32'h0, v, e);
    fw.idle();
    check("abort irq", v & 32'h2, 32'h2);
    rchk("address", `EDA_OFF_ADDRESS, 32'h0);
    rchk("data", `EDA_OFF_DATA, 32'h0);
    do_rst(1'b0);
    fw.xfer(1'b0, `EDA_OFF_CONTROL, 32'h0, v, e);
    fw.idle();
    check("permit", v & 32'h6, 32'h0);
    close_out();
  end
endmodule : eda_ctrl_tb_top
